// *** inc/wrc_pkg.sv ***
`default_nettype none

package wrc_pkg;

    localparam int          WRC_NUM_CH      = 5;
    localparam int          WRC_VAL_W       = 32;
    localparam int          WRC_LABEL_CHARS = 20;
    localparam int          WRC_LABEL_W     = WRC_LABEL_CHARS * 8;
    localparam int          WRC_IDX_W       = 3;
    // channel indices run from one up to the channel count
    localparam logic [2:0]  WRC_FIRST_IDX   = 3'h1;
    localparam logic [2:0]  WRC_LAST_IDX    = 3'h5;

    typedef enum logic [2:0] {
        WRC_SRC_NONE,
        WRC_SRC_APP,
        WRC_SRC_MAG_DISP,
        WRC_SRC_MAG_RATE,
        WRC_SRC_DISP,
        WRC_SRC_GROSS,
        WRC_SRC_RATE
    } wrc_src_t;

    typedef enum logic [2:0] {
        WRC_OP_LT,
        WRC_OP_LE,
        WRC_OP_EQ,
        WRC_OP_GT,
        WRC_OP_NE,
        WRC_OP_OUT_RANGE,
        WRC_OP_IN_RANGE
    } wrc_op_t;

    typedef struct packed {
        wrc_src_t                       src;
        wrc_op_t                        op;
        logic signed [WRC_VAL_W-1:0]    limit;
        logic signed [WRC_VAL_W-1:0]    high_limit;
        logic [WRC_LABEL_W-1:0]         label;
    } wrc_cfg_t;

    typedef struct packed {
        logic signed [WRC_VAL_W-1:0]    displayed;
        logic signed [WRC_VAL_W-1:0]    gross;
        logic signed [WRC_VAL_W-1:0]    rate;
    } wrc_meas_t;

    typedef struct packed {
        wrc_cfg_t [WRC_NUM_CH-1:0]      cfg;
        logic [WRC_NUM_CH-1:0]          held;
        logic                           cfg_err;
        logic [WRC_LABEL_W-1:0]         rd_label;
    } wrc_state_t;

    localparam wrc_cfg_t WRC_CFG_RESET = '{
        src:        WRC_SRC_NONE,
        op:         WRC_OP_LT,
        limit:      '0,
        high_limit: '0,
        label:      '0
    };

    localparam wrc_state_t WRC_STATE_RESET = '{
        cfg:      {WRC_NUM_CH{WRC_CFG_RESET}},
        held:     '0,
        cfg_err:  1'b0,
        rd_label: '0
    };

endpackage

`default_nettype wire

// *** core/wrc_bank.sv ***
// How it works
// [RQ1] five independent channels, addressed by fixed index one to five
// [RQ2] source picks displayed, gross or rate; source none disables the channel
// [RQ3] magnitude sources compare the absolute value of displayed weight or rate
// [RQ4] application source: result comes from the external program, not limits
// [RQ5] less-than: on exactly while source is below the limit
// [RQ6] less-or-equal: on while source does not exceed the limit
// [RQ7] equal: on only while source matches the limit
// [RQ8] greater-than: on exactly while source exceeds the limit
// [RQ9] not-equal: on whenever source differs from the limit
// [RQ10] out-of-range: on while source lies outside limit..high limit
// [RQ11] in-range: on while source lies inside limit..high limit
// [RQ12] limit is the single value, or the lower bound for range operators
// [RQ13] high limit is used only by the two range operators
// [RQ14] range operator with high limit not above limit: reject, flag error, keep old setup
// [RQ15] each channel stores a twenty-character label
// [RQ16] delete one channel or clear all; affected channels end disabled
// [RQ17] enabled channels re-evaluate and update output in the sample's cycle
`timescale 1ns/1ps
`default_nettype none

module wrc_bank (
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire wrc_pkg::wrc_meas_t             meas,
    input  wire logic                           meas_valid,
    input  wire logic [wrc_pkg::WRC_NUM_CH-1:0] app_result,
    input  wire logic                           cfg_wr,
    input  wire logic                           cfg_delete,
    input  wire logic                           cfg_clear_all,
    input  wire logic [wrc_pkg::WRC_IDX_W-1:0]  cfg_idx,
    input  wire wrc_pkg::wrc_cfg_t              cfg_data,
    input  wire logic [wrc_pkg::WRC_IDX_W-1:0]  rd_idx,
    output logic [wrc_pkg::WRC_NUM_CH-1:0]      cmp_out,
    output logic                                cfg_err,
    output logic [wrc_pkg::WRC_LABEL_W-1:0]     rd_label
);

    wrc_pkg::wrc_state_t            st;
    wrc_pkg::wrc_state_t            next_st;
    logic [wrc_pkg::WRC_NUM_CH-1:0] fresh;
    logic [wrc_pkg::WRC_NUM_CH-1:0] live;
    logic                           cfg_idx_ok;
    logic                           rd_idx_ok;

    // 33 bits so the magnitude of the most negative value still fits
    function automatic logic evaluate(input wrc_pkg::wrc_cfg_t c,
                                      input wrc_pkg::wrc_meas_t m,
                                      input logic app);
        logic signed [32:0] v;
        logic signed [32:0] lo;
        logic signed [32:0] hi;
        logic               r;
        v  = '0;
        lo = {c.limit[31], c.limit};
        hi = {c.high_limit[31], c.high_limit};
        r  = 1'b0;
        unique case (c.src)
            wrc_pkg::WRC_SRC_NONE:     v = '0;
            wrc_pkg::WRC_SRC_APP:      v = '0;
            wrc_pkg::WRC_SRC_MAG_DISP: v = m.displayed[31] ? -{1'b1, m.displayed}
                                                           : {1'b0, m.displayed}; // RQ3
            wrc_pkg::WRC_SRC_MAG_RATE: v = m.rate[31] ? -{1'b1, m.rate}
                                                      : {1'b0, m.rate}; // RQ3
            wrc_pkg::WRC_SRC_DISP:     v = {m.displayed[31], m.displayed}; // RQ2
            wrc_pkg::WRC_SRC_GROSS:    v = {m.gross[31], m.gross}; // RQ2
            wrc_pkg::WRC_SRC_RATE:     v = {m.rate[31], m.rate}; // RQ2
            default:                   v = '0;
        endcase
        // lo is the lone comparand or the lower bound; hi only for ranges
        unique case (c.op)
            wrc_pkg::WRC_OP_LT:        r = v < lo; // RQ5 RQ12
            wrc_pkg::WRC_OP_LE:        r = v <= lo; // RQ6
            wrc_pkg::WRC_OP_EQ:        r = v == lo; // RQ7
            wrc_pkg::WRC_OP_GT:        r = v > lo; // RQ8
            wrc_pkg::WRC_OP_NE:        r = v != lo; // RQ9
            wrc_pkg::WRC_OP_OUT_RANGE: r = (v < lo) || (v > hi); // RQ10 RQ13
            wrc_pkg::WRC_OP_IN_RANGE:  r = (v >= lo) && (v <= hi); // RQ11 RQ13
            default:                   r = 1'b0;
        endcase
        if (c.src == wrc_pkg::WRC_SRC_NONE) begin
            return 1'b0; // RQ2
        end
        if (c.src == wrc_pkg::WRC_SRC_APP) begin
            return app; // RQ4
        end
        return r;
    endfunction

    assign cfg_idx_ok = (cfg_idx >= wrc_pkg::WRC_FIRST_IDX) && (cfg_idx <= wrc_pkg::WRC_LAST_IDX);
    assign rd_idx_ok  = (rd_idx >= wrc_pkg::WRC_FIRST_IDX) && (rd_idx <= wrc_pkg::WRC_LAST_IDX);

    genvar gi;
    generate
        for (gi = 0; gi < wrc_pkg::WRC_NUM_CH; gi++) begin : g_ch
            assign fresh[gi] = evaluate(st.cfg[gi], meas, app_result[gi]); // RQ1
            // application channels follow the program every cycle
            assign live[gi]  = meas_valid || (st.cfg[gi].src == wrc_pkg::WRC_SRC_APP);
            // result shows in the sample's own cycle, then holds until the next
            assign cmp_out[gi] = (st.cfg[gi].src == wrc_pkg::WRC_SRC_NONE) ? 1'b0
                               : (live[gi] ? fresh[gi] : st.held[gi]); // RQ17 RQ2
        end
    endgenerate

    always_comb begin
        next_st         = st;
        next_st.cfg_err = 1'b0;
        for (int i = 0; i < wrc_pkg::WRC_NUM_CH; i++) begin
            if (live[i]) begin
                next_st.held[i] = fresh[i]; // RQ17
            end
        end
        if (cfg_clear_all) begin
            for (int i = 0; i < wrc_pkg::WRC_NUM_CH; i++) begin
                next_st.cfg[i] = wrc_pkg::WRC_CFG_RESET; // RQ16
            end
        end else if (cfg_delete) begin
            if (cfg_idx_ok) begin
                next_st.cfg[cfg_idx - wrc_pkg::WRC_FIRST_IDX] = wrc_pkg::WRC_CFG_RESET; // RQ16
            end else begin
                next_st.cfg_err = 1'b1;
            end
        end else if (cfg_wr) begin
            if (!cfg_idx_ok) begin
                next_st.cfg_err = 1'b1;
            end else if ((cfg_data.op == wrc_pkg::WRC_OP_OUT_RANGE
                          || cfg_data.op == wrc_pkg::WRC_OP_IN_RANGE)
                         && (cfg_data.high_limit <= cfg_data.limit)) begin
                next_st.cfg_err = 1'b1; // RQ14
            end else begin
                // label travels with the rest of the channel setup
                next_st.cfg[cfg_idx - wrc_pkg::WRC_FIRST_IDX] = cfg_data; // RQ15
            end
        end
        next_st.rd_label = rd_idx_ok ? st.cfg[rd_idx - wrc_pkg::WRC_FIRST_IDX].label
                                     : '0; // RQ15
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= wrc_pkg::WRC_STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_err  = st.cfg_err;
    assign rd_label = st.rd_label;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic bad_high;
    assign bad_high = cfg_wr && !cfg_delete && !cfg_clear_all && cfg_idx_ok
                      && (cfg_data.op == wrc_pkg::WRC_OP_IN_RANGE
                          || cfg_data.op == wrc_pkg::WRC_OP_OUT_RANGE)
                      && (cfg_data.high_limit <= cfg_data.limit);

    generate
        for (gi = 0; gi < wrc_pkg::WRC_NUM_CH; gi++) begin : g_chk
            chk_none_stays_off: assert property ( // RQ2
                st.cfg[gi].src == wrc_pkg::WRC_SRC_NONE |-> !cmp_out[gi])
                else $error("disabled channel asserted");
            chk_lt_gross_value: assert property ( // RQ5
                meas_valid && st.cfg[gi].src == wrc_pkg::WRC_SRC_GROSS
                && st.cfg[gi].op == wrc_pkg::WRC_OP_LT
                |-> cmp_out[gi] == (meas.gross < st.cfg[gi].limit))
                else $error("less-than result wrong");
            chk_le_disp_value: assert property ( // RQ6
                meas_valid && st.cfg[gi].src == wrc_pkg::WRC_SRC_DISP
                && st.cfg[gi].op == wrc_pkg::WRC_OP_LE
                |-> cmp_out[gi] == (meas.displayed <= st.cfg[gi].limit))
                else $error("less-or-equal result wrong");
            chk_eq_ne_rate: assert property ( // RQ7 RQ9
                meas_valid && st.cfg[gi].src == wrc_pkg::WRC_SRC_RATE
                && (st.cfg[gi].op == wrc_pkg::WRC_OP_EQ || st.cfg[gi].op == wrc_pkg::WRC_OP_NE)
                |-> cmp_out[gi] == ((meas.rate == st.cfg[gi].limit)
                                   == (st.cfg[gi].op == wrc_pkg::WRC_OP_EQ)))
                else $error("equality result wrong");
            chk_gt_magnitude: assert property ( // RQ3 RQ8
                meas_valid && st.cfg[gi].src == wrc_pkg::WRC_SRC_MAG_RATE
                && st.cfg[gi].op == wrc_pkg::WRC_OP_GT && !meas.rate[31]
                |-> cmp_out[gi] == (meas.rate > st.cfg[gi].limit))
                else $error("magnitude greater-than wrong");
            chk_range_inverse: assert property ( // RQ10 RQ11
                meas_valid && st.cfg[gi].src == wrc_pkg::WRC_SRC_GROSS
                && (st.cfg[gi].op == wrc_pkg::WRC_OP_IN_RANGE
                    || st.cfg[gi].op == wrc_pkg::WRC_OP_OUT_RANGE)
                |-> cmp_out[gi] == ((meas.gross >= st.cfg[gi].limit
                                     && meas.gross <= st.cfg[gi].high_limit)
                                    == (st.cfg[gi].op == wrc_pkg::WRC_OP_IN_RANGE)))
                else $error("range result wrong");
            chk_delete_one_off: assert property ( // RQ16
                cfg_delete && !cfg_clear_all && cfg_idx == wrc_pkg::WRC_FIRST_IDX + 3'(gi)
                |=> st.cfg[gi].src == wrc_pkg::WRC_SRC_NONE && !cmp_out[gi])
                else $error("deleted channel still active");
            chk_app_follows: assert property ( // RQ4
                st.cfg[gi].src == wrc_pkg::WRC_SRC_APP |-> cmp_out[gi] == app_result[gi])
                else $error("application result not followed");
            chk_hold_between: assert property ( // RQ17
                !meas_valid && $stable(st.cfg[gi]) && st.cfg[gi].src != wrc_pkg::WRC_SRC_APP
                && st.cfg[gi].src != wrc_pkg::WRC_SRC_NONE && $past(rst_n)
                |-> cmp_out[gi] == $past(cmp_out[gi]))
                else $error("output moved without a sample");
        end
    endgenerate

    chk_bad_high_kept: assert property ( // RQ14
        bad_high |=> cfg_err && st.cfg == $past(st.cfg))
        else $error("invalid high limit was accepted");
    chk_bad_idx_flag: assert property ( // RQ1
        (cfg_wr || cfg_delete) && !cfg_clear_all && !cfg_idx_ok |=> cfg_err && $stable(st.cfg))
        else $error("out-of-range index not refused");
    chk_clear_all_off: assert property ( // RQ16
        cfg_clear_all |=> cmp_out == '0 ##0 st.cfg[0].src == wrc_pkg::WRC_SRC_NONE)
        else $error("clear all left a channel active");

    cov_bad_high: cover property (bad_high ##1 cfg_err);
    cov_in_range_on: cover property (meas_valid && cmp_out[0]
                                     && st.cfg[0].op == wrc_pkg::WRC_OP_IN_RANGE);
    cov_mag_negative: cover property (meas_valid && meas.displayed[31] && cmp_out[1]
                                      && st.cfg[1].src == wrc_pkg::WRC_SRC_MAG_DISP);
    cov_delete_one: cover property (cfg_delete && cfg_idx_ok ##1 !cfg_err);

endmodule

`default_nettype wire

// *** verification/wrc_meas_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module wrc_meas_src (
    input  wire logic                           ref_clk,
    input  wire logic                           smp_req,
    input  wire wrc_pkg::wrc_meas_t             smp_val,
    input  wire logic [wrc_pkg::WRC_NUM_CH-1:0] app_val,
    output logic                                meas_valid,
    output wrc_pkg::wrc_meas_t                  meas,
    output logic [wrc_pkg::WRC_NUM_CH-1:0]      app_result
);
    wrc_pkg::wrc_meas_t last = '0;

    always @(posedge ref_clk) begin
        if (smp_req) begin
            last <= smp_val;
        end
    end

    // off-sample the bus shows inverted junk, so a late read is caught
    assign meas       = smp_req ? smp_val : ~last;
    assign meas_valid = smp_req;
    // the application program alone decides these results
    assign app_result = app_val;
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic               ref_clk       = 1'b0;
    logic               rst_n         = 1'b0;
    logic               smp_req       = 1'b0;
    wrc_pkg::wrc_meas_t smp_val       = '0;
    logic [4:0]         app_val       = 5'h00;
    logic               cfg_wr        = 1'b0;
    logic               cfg_delete    = 1'b0;
    logic               cfg_clear_all = 1'b0;
    logic [2:0]         cfg_idx       = 3'h1;
    wrc_pkg::wrc_cfg_t  cfg_data      = wrc_pkg::WRC_CFG_RESET;
    logic [2:0]         rd_idx        = 3'h1;
    wrc_pkg::wrc_meas_t meas;
    logic               meas_valid;
    logic [4:0]         app_result;
    logic [4:0]         cmp_out;
    logic               cfg_err;
    logic [159:0]       rd_label;
    int                 n_fail        = 0;
    int                 total_checks  = 0;
    int                 s_src [1:5]   = '{0, 0, 0, 0, 0};
    int                 s_op [1:5]    = '{0, 0, 0, 0, 0};
    longint             s_lo [1:5]    = '{0, 0, 0, 0, 0};
    longint             s_hi [1:5]    = '{0, 0, 0, 0, 0};
    longint             vals [11]     = '{-21, -20, -11, -10, 7, 9, 10, 11, 17, 20, 21};

    always #2.5 ref_clk = ~ref_clk;

    wrc_meas_src i_wrc_meas_src (.ref_clk(ref_clk), .smp_req(smp_req), .smp_val(smp_val),
        .app_val(app_val), .meas_valid(meas_valid), .meas(meas), .app_result(app_result));

    wrc_bank i_wrc_bank (.ref_clk(ref_clk), .rst_n(rst_n), .meas(meas), .meas_valid(meas_valid),
        .app_result(app_result), .cfg_wr(cfg_wr), .cfg_delete(cfg_delete),
        .cfg_clear_all(cfg_clear_all), .cfg_idx(cfg_idx), .cfg_data(cfg_data),
        .rd_idx(rd_idx), .cmp_out(cmp_out), .cfg_err(cfg_err), .rd_label(rd_label));

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [159:0] e, input logic [159:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [4:0] expect_out(input longint d, input longint g, input longint r);
        logic [4:0] e;
        longint     v;
        bit         on;
        e = 5'h00;
        for (int i = 1; i <= 5; i++) begin
            case (s_src[i])
                2: v = (d < 0) ? -d : d;
                3: v = (r < 0) ? -r : r;
                4: v = d;
                5: v = g;
                default: v = r;
            endcase
            case (s_op[i])
                0: on = v < s_lo[i];
                1: on = v <= s_lo[i];
                2: on = v == s_lo[i];
                3: on = v > s_lo[i];
                4: on = v != s_lo[i];
                5: on = v < s_lo[i] || v > s_hi[i];
                default: on = v >= s_lo[i] && v <= s_hi[i];
            endcase
            if (s_src[i] == 0) on = 1'b0;
            if (s_src[i] == 1) on = app_val[i-1];
            e[i-1] = on;
        end
        return e;
    endfunction

    task automatic wr(input int idx, input int src, input int op, input longint lo,
                      input longint hi, input logic err);
        cfg_idx = 3'(idx);
        cfg_data.src = wrc_pkg::wrc_src_t'(src);
        cfg_data.op = wrc_pkg::wrc_op_t'(op);
        cfg_data.limit = 32'(lo);
        cfg_data.high_limit = 32'(hi);
        cfg_data.label = {32{5'(idx)}};
        cfg_wr = 1'b1;
        tick();
        cfg_wr = 1'b0;
        chk("cfg_err", err, cfg_err);
        if (!err) begin
            s_src[idx] = src;
            s_op[idx] = op;
            s_lo[idx] = lo;
            s_hi[idx] = hi;
        end
        tick();
    endtask

    task automatic smp(input longint v);
        smp_val.displayed = 32'(v);
        smp_val.gross = 32'(v + 3);
        smp_val.rate = 32'(-v);
        smp_req = 1'b1;
        #1;
        chk("cmp_out", expect_out(v, v + 3, -v), cmp_out);
        tick();
        smp_req = 1'b0;
        #1;
        chk("cmp_out held", expect_out(v, v + 3, -v), cmp_out);
        tick();
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_fail++;
        $display("Error watchdog expected done seen hang");
        conclude();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk("cmp_out", 5'h00, cmp_out);
        chk("cfg_err", 1'b0, cfg_err);
        // sources rotate over channels so each channel meets all five measured sources (never none or application)
        for (int op = 0; op < 7; op++) begin
            for (int c = 1; c <= 5; c++) begin
                wr(c, 2 + (c + op) % 5, op, 10, (op >= 5) ? 20 : 5, 1'b0);
            end
            foreach (vals[k]) smp(vals[k]);
        end
        $display("operator test done");
        wr(3, 4, 6, 10, 10, 1'b1);
        wr(3, 4, 5, 10, 9, 1'b1);
        wr(0, 4, 0, 10, 20, 1'b1);
        wr(6, 4, 0, 10, 20, 1'b1);
        smp(9);
        smp(21);
        wr(2, 1, 3, 10, 5, 1'b0);
        app_val = 5'h02;
        #1;
        chk("cmp_out app", 1'b1, cmp_out[1]);
        tick();
        app_val = 5'h00;
        #1;
        chk("cmp_out app", 1'b0, cmp_out[1]);
        tick();
        $display("refusal and application test done");
        rd_idx = 3'h4;
        tick();
        tick();
        chk("rd_label", {32{5'h04}}, rd_label);
        rd_idx = 3'h0;
        tick();
        tick();
        chk("rd_label", 160'h0, rd_label);
        cfg_idx = 3'h7;
        cfg_delete = 1'b1;
        tick();
        cfg_delete = 1'b0;
        chk("cfg_err delete", 1'b1, cfg_err);
        tick();
        smp(-10);
        cfg_idx = 3'h4;
        cfg_delete = 1'b1;
        tick();
        cfg_delete = 1'b0;
        chk("cmp_out delete", 1'b0, cmp_out[3]);
        tick();
        cfg_clear_all = 1'b1;
        tick();
        cfg_clear_all = 1'b0;
        app_val = 5'h1f;
        #1;
        chk("cmp_out clear", 5'h00, cmp_out);
        tick();
        $display("delete and clear test done");
        conclude();
    end
endmodule

`default_nettype wire
